// *** verilog/shifter_flags_cfg.svh ***
/*
  Constants for the shifter, flag and condition slice: condition codes,
  register offsets, field positions and reset values.
  Assumes inclusion by bare name from the top module and the bench.
*/
`ifndef SHIFTER_FLAGS_CFG_SVH
`define SHIFTER_FLAGS_CFG_SVH

`define APB_AW 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define CTRL_TRAP_BIT 0
`define STATUS_FAULT_BIT 4
`define CTRL_RESET 1'h0
`define PC_AHEAD 32'h0000_0004
`define PC_WORD_BIT 1

`define CC_EQ 4'h0
`define CC_NE 4'h1
`define CC_CS 4'h2
`define CC_CC 4'h3
`define CC_MI 4'h4
`define CC_PL 4'h5
`define CC_VS 4'h6
`define CC_VC 4'h7
`define CC_HI 4'h8
`define CC_LS 4'h9
`define CC_GE 4'hA
`define CC_LT 4'hB
`define CC_GT 4'hC
`define CC_LE 4'hD
`define CC_AL 4'hE

`endif

// *** verilog/shifter_flags_pkg.sv ***
/*
  Types shared by the shifter and flag slice and its surroundings.
  Assumes the decode logic fills one request per cycle on the core clock.
*/
package shifter_flags_pkg;

  typedef enum logic [2:0] {
    ALU_MOVE, ALU_AND, ALU_ORR, ALU_EOR, ALU_ADD, ALU_SUB,
    ALU_COMP_SUB, ALU_COMP_ADD
  } alu_op_t;

  typedef enum logic [1:0] {SH_LEFT, SH_ROT, SH_ROT_CARRY} shift_op_t;

  typedef enum logic [2:0] {
    MEM_NONE, MEM_BYTE, MEM_HALF, MEM_WORD, MEM_DUAL, MEM_MULTI
  } mem_kind_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } flags_t;

  typedef struct packed {
    logic valid;
    alu_op_t alu;
    shift_op_t shift;
    logic [7:0] amount;
    logic setFlags;
    logic [3:0] cond;
    logic [31:0] operandA;
    logic [31:0] operandB;
    mem_kind_t memKind;
    logic unalignOk;
    logic [31:0] memAddr;
    logic directBranch;
    logic [31:0] instrAddr;
  } exec_req_t;

  typedef struct packed {
    logic done;
    logic executed;
    logic writeEn;
    logic fault;
    logic [31:0] result;
    logic [31:0] pcValue;
  } exec_rsp_t;

endpackage

// *** verilog/shifter_and_condition_flags.sv ***
/*
  Execute slice: barrel shifter, ALU flag generation, condition check,
  alignment check and PC operand, plus a small APB register file.
  Assumes decode presents a request on the core clock and takes the
  registered answer one cycle later; APB runs on the same clock.
*/
// Function
// - Left shift moves low 32-n bits up, zero fills, no overflow.
// - Flag-setting left shift by non-zero n loads carry from bit 32-n.
// - Left shift by zero leaves carry unchanged.
// - Left shift 32 or more gives zero; 33 or more clears carry.
// - Rotate right moves upper bits down, low n bits to the top.
// - Flag-setting rotate right loads carry from bit n-1.
// - Rotate by 32 returns operand; carry takes bit 31.
// - Rotate beyond 32 equals rotate by length minus 32.
// - Rotate through carry shifts right one, carry into bit 31.
// - Flag-setting rotate through carry loads carry from bit 0.
// - Bytes always aligned; words need word, halfwords halfword alignment.
// - Only single word and halfword accesses may be unaligned; others fault.
// - Trap enable makes every unaligned access fault.
// - Direct branches use instruction address plus four as PC.
// - Other label users get address plus four with bit 1 cleared.
// - Failed condition: no execution, write, flag change or fault.
// - Flags not updated keep their value; only flag-setting ops update.
// - N marks negative, Z zero, C carry, V overflow; otherwise zero.
// - Carry from add reaching 2^32, subtract without borrow, or shifter.
// - Overflow when result sign differs from infinite-precision sign.
// - Compares set flags like subtract or add and discard result.
// - Decode single-flag conditions; carry set is unsigned higher-or-same.
// - Decode compound unsigned and signed comparisons.
// - No condition means always execute.
// - Zero shift length passes operand and leaves carry untouched; rotate through carry ignores the length and still shifts by one.
`timescale 1ns/1ps
`include "shifter_flags_cfg.svh"

module shifter_and_condition_flags (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire shifter_flags_pkg::exec_req_t req,
  output shifter_flags_pkg::exec_rsp_t rsp,
  output shifter_flags_pkg::flags_t flags,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ************************************************************
  // Decode functions
  // ************************************************************

  function automatic logic condPass(input logic [3:0] code,
                                    input shifter_flags_pkg::flags_t f);
    logic pass;
    pass = 1'b1;
    case (code)
      `CC_EQ: pass = f.z;
      `CC_NE: pass = !f.z;
      `CC_CS: pass = f.c;
      `CC_CC: pass = !f.c;
      `CC_MI: pass = f.n;
      `CC_PL: pass = !f.n;
      `CC_VS: pass = f.v;
      `CC_VC: pass = !f.v;
      `CC_HI: pass = f.c && !f.z;
      `CC_LS: pass = !f.c || f.z;
      `CC_GE: pass = f.n == f.v;
      `CC_LT: pass = f.n != f.v;
      `CC_GT: pass = !f.z && (f.n == f.v);
      `CC_LE: pass = f.z || (f.n != f.v);
      // Always, also for the spare code
      default: pass = 1'b1;
    endcase
    return pass;
  endfunction

  function automatic logic misaligned(
      input shifter_flags_pkg::mem_kind_t kind, input logic [31:0] addr);
    logic bad;
    bad = 1'b0;
    case (kind)
      shifter_flags_pkg::MEM_HALF: bad = addr[0];
      shifter_flags_pkg::MEM_WORD,
      shifter_flags_pkg::MEM_DUAL,
      shifter_flags_pkg::MEM_MULTI: bad = |addr[1:0];
      default: bad = 1'b0;
    endcase
    return bad;
  endfunction

  // Returns {carry, result}; carry is cin where the shift leaves it alone
  function automatic logic [32:0] shiftOp(
      input shifter_flags_pkg::shift_op_t op, input logic [31:0] val,
      input logic [7:0] amt, input logic cin);
    logic [32:0] out;
    logic [63:0] dbl;
    out = {cin, val};
    dbl = {val, val} >> amt[4:0];
    case (op)
      shifter_flags_pkg::SH_LEFT: begin
        // Left shift; 33-bit result catches bit 32-n as carry
        // Zero length holds carry; past 32 all bits leave
        if (amt != 8'h00) begin
          out = {1'b0, val} << amt;
        end
      end
      shifter_flags_pkg::SH_ROT: begin
        // Rotate; carry is the last bit rotated, now at bit 31
        // Multiples of 32 leave the word, carry bit 31
        // Low five length bits set the rotation; any non-zero length loads carry
        if (amt != 8'h00) begin
          out = {dbl[31], dbl[31:0]};
        end
      end
      shifter_flags_pkg::SH_ROT_CARRY: begin
        out = {val[0], cin, val[31:1]};
      end
      default: out = {cin, val};
    endcase
    return out;
  endfunction

  // ************************************************************
  // Execute datapath
  // ************************************************************

  logic trapEnable;
  logic lastFault;
  logic pass;
  logic memFault;
  logic isCompare;
  logic carryOut;
  logic ovf;
  logic [32:0] shifted;
  logic [32:0] sum;
  logic [32:0] diff;
  logic [31:0] aluOut;
  logic [31:0] pcBase;
  shifter_flags_pkg::flags_t next_flags;
  shifter_flags_pkg::exec_rsp_t next_rsp;
  logic next_lastFault;

  always_comb begin
    // Result and carry-out from one shifter pass
    // Zero length on left shift or rotate keeps operand and incoming carry
    shifted = shiftOp(req.shift, req.operandB, req.amount, flags.c);
    pass = condPass(req.cond, flags);
    sum = {1'b0, req.operandA} + {1'b0, shifted[31:0]};
    diff = {1'b0, req.operandA} + {1'b0, ~shifted[31:0]} + 33'h0_0000_0001;
    aluOut = shifted[31:0];
    // Moves and logicals take the shifter's carry
    carryOut = shifted[32];
    ovf = flags.v;
    isCompare = 1'b0;
    unique case (req.alu)
      shifter_flags_pkg::ALU_MOVE: aluOut = shifted[31:0];
      shifter_flags_pkg::ALU_AND: aluOut = req.operandA & shifted[31:0];
      shifter_flags_pkg::ALU_ORR: aluOut = req.operandA | shifted[31:0];
      shifter_flags_pkg::ALU_EOR: aluOut = req.operandA ^ shifted[31:0];
      shifter_flags_pkg::ALU_ADD,
      shifter_flags_pkg::ALU_COMP_ADD: begin
        // Carry when the sum reaches 2^32
        // Same-sign operands giving the other sign
        aluOut = sum[31:0];
        carryOut = sum[32];
        ovf = (req.operandA[31] == shifted[31]) &&
              (sum[31] != req.operandA[31]);
        isCompare = req.alu == shifter_flags_pkg::ALU_COMP_ADD;
      end
      shifter_flags_pkg::ALU_SUB,
      shifter_flags_pkg::ALU_COMP_SUB: begin
        // Opposite-sign operands flipping the minuend's sign
        aluOut = diff[31:0];
        carryOut = diff[32];
        ovf = (req.operandA[31] != shifted[31]) &&
              (diff[31] != req.operandA[31]);
        isCompare = req.alu == shifter_flags_pkg::ALU_COMP_SUB;
      end
    endcase
    // Only single word and halfword accesses tolerate misalignment
    memFault = misaligned(req.memKind, req.memAddr) &&
               (trapEnable || !req.unalignOk ||
                req.memKind == shifter_flags_pkg::MEM_DUAL ||
                req.memKind == shifter_flags_pkg::MEM_MULTI);
    // Direct branches see address plus four
    pcBase = req.instrAddr + `PC_AHEAD;
    // Other label users see it word aligned
    if (!req.directBranch) begin
      pcBase[`PC_WORD_BIT] = 1'b0;
    end
    next_flags = flags;
    next_lastFault = lastFault;
    next_rsp = '0;
    next_rsp.done = req.valid;
    next_rsp.result = aluOut;
    next_rsp.pcValue = pcBase;
    // A failed condition leaves all state and raises nothing
    if (req.valid && pass) begin
      next_rsp.executed = 1'b1;
      next_rsp.fault = memFault;
      next_rsp.writeEn = !isCompare && !memFault;
      next_lastFault = memFault;
      if (req.setFlags && !memFault) begin
        next_flags.n = aluOut[31];
        next_flags.z = aluOut == 32'h0000_0000;
        next_flags.c = carryOut;
        next_flags.v = ovf;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      flags <= '0;
      rsp <= '0;
      lastFault <= 1'b0;
    end else begin
      flags <= next_flags;
      rsp <= next_rsp;
      lastFault <= next_lastFault;
    end
  end

  // ************************************************************
  // APB registers
  // ************************************************************

  // One wait state keeps pready and prdata straight from flip-flops
  logic apbDone;
  logic mapped;
  logic next_trapEnable;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;

  always_comb begin
    apbDone = psel && penable && pready;
    mapped = (paddr == `REG_CTRL) || (paddr == `REG_STATUS);
    next_pready = psel && penable && !pready;
    next_pslverr = next_pready && !mapped;
    next_prdata = 32'h0000_0000;
    next_trapEnable = trapEnable;
    if (next_pready && !pwrite && paddr == `REG_CTRL) begin
      next_prdata[`CTRL_TRAP_BIT] = trapEnable;
    end
    if (next_pready && !pwrite && paddr == `REG_STATUS) begin
      next_prdata[3:0] = flags;
      next_prdata[`STATUS_FAULT_BIT] = lastFault;
    end
    if (apbDone && pwrite && paddr == `REG_CTRL) begin
      next_trapEnable = pwdata[`CTRL_TRAP_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      trapEnable <= `CTRL_RESET;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      trapEnable <= next_trapEnable;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_cond_fail_quiet:
    assert property (req.valid && !pass |=>
                     $stable(flags) && !rsp.writeEn && !rsp.fault)
    else $error("failed condition changed state");

  a_no_suffix_hold:
    assert property (!req.setFlags |=> $stable(flags))
    else $error("flags changed without flag update");

  a_left_zero_carry:
    assert property (req.valid && pass && req.setFlags &&
                     req.shift == shifter_flags_pkg::SH_LEFT &&
                     req.amount == 8'h00 &&
                     req.alu == shifter_flags_pkg::ALU_MOVE |=>
                     flags.c == $past(flags.c) &&
                     rsp.result == $past(req.operandB))
    else $error("zero left shift touched carry or data");

  a_left_wide_zero:
    assert property (req.valid && req.shift == shifter_flags_pkg::SH_LEFT &&
                     req.amount >= 8'h20 &&
                     req.alu == shifter_flags_pkg::ALU_MOVE |=>
                     rsp.result == 32'h0000_0000)
    else $error("wide left shift not zero");

  a_rot_carry_top:
    assert property (req.valid && pass && req.setFlags && !memFault &&
                     req.shift == shifter_flags_pkg::SH_ROT &&
                     req.amount != 8'h00 &&
                     req.alu == shifter_flags_pkg::ALU_MOVE |=>
                     flags.c == rsp.result[31])
    else $error("rotate carry wrong");

  a_ext_carry_swap:
    assert property (req.valid && pass && req.setFlags && !memFault &&
                     req.shift == shifter_flags_pkg::SH_ROT_CARRY &&
                     req.alu == shifter_flags_pkg::ALU_MOVE |=>
                     flags.c == $past(req.operandB[0]) &&
                     rsp.result[31] == $past(flags.c))
    else $error("rotate through carry wrong");

  a_zero_flag_match:
    assert property (req.valid && pass && req.setFlags && !memFault |=>
                     flags.z == (rsp.result == 32'h0000_0000) &&
                     flags.n == rsp.result[31])
    else $error("N or Z disagrees with result");

  a_byte_never_fault:
    assert property (req.valid && req.memKind == shifter_flags_pkg::MEM_BYTE
                     |=> !rsp.fault)
    else $error("byte access faulted");

  a_trap_all_unaligned:
    assert property (req.valid && pass && trapEnable &&
                     misaligned(req.memKind, req.memAddr) |=> rsp.fault)
    else $error("unaligned access not trapped");

  a_pc_word_aligned:
    assert property (req.valid && !req.directBranch |=>
                     !rsp.pcValue[`PC_WORD_BIT] &&
                     rsp.pcValue[31:2] == $past(req.instrAddr[31:2]) + 30'h1)
    else $error("label PC not word aligned");

  a_pc_branch_ahead:
    assert property (req.valid && req.directBranch |=>
                     rsp.pcValue == $past(req.instrAddr) + `PC_AHEAD)
    else $error("branch PC not address plus four");

  a_compare_discard:
    assert property (req.valid && pass &&
                     (req.alu == shifter_flags_pkg::ALU_COMP_SUB ||
                      req.alu == shifter_flags_pkg::ALU_COMP_ADD) |=>
                     !rsp.writeEn)
    else $error("compare wrote a result");

  a_apb_one_wait: // APB wait state
    assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("APB answer not one wait state");

endmodule

// *** test/decode_model.sv ***
/*
  Stand-in for the decode and register-file side: one request register.
  Assumes the bench loads cmd once per rising edge of the core clock.
*/
`timescale 1ns/1ps

module decode_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire shifter_flags_pkg::exec_req_t cmd,
  output shifter_flags_pkg::exec_req_t req
);
  shifter_flags_pkg::exec_req_t next_req;

  // Reset with the core so no stale request leaks out
  always_comb begin
    next_req = cmd;
    if (!rst_b) next_req = '0;
  end

  always_ff @(posedge ref_clk) begin
    req <= next_req;
  end
endmodule

// *** test/shifter_and_condition_flags_bench.sv ***
/*
  Self-checking bench: random and directed requests through the decode
  model, expected answers queued at issue time, APB register checks.
  Assumes the package, the cfg header and decode_model compile first.
*/
`timescale 1ns/1ps
`include "shifter_flags_cfg.svh"

module shifter_and_condition_flags_bench;
  typedef struct {
    logic [31:0] res;
    logic [31:0] pc;
    logic [3:0] fl;
    logic [2:0] st;
    logic chk;
  } exp_t;
  logic refClk = 0;
  logic rstB = 0;
  shifter_flags_pkg::exec_req_t cmd = '0;
  shifter_flags_pkg::exec_req_t req;
  shifter_flags_pkg::exec_rsp_t rsp;
  shifter_flags_pkg::flags_t flags;
  shifter_flags_pkg::flags_t mf = '0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, trap = 0;
  logic lastFault = 0;
  logic [`APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h72E1;
  logic [7:0] amts [7] = '{8'h0, 8'h1, 8'h1F, 8'h20, 8'h21, 8'h28, 8'h40};
  int badCount = 0, nTests = 0;
  exp_t q [$];
  exp_t got;
  shifter_flags_pkg::exec_req_t r;

  initial forever #2 refClk = ~refClk;

  decode_model partner (.ref_clk(refClk), .rst_b(rstB), .cmd(cmd),
    .req(req));
  shifter_and_condition_flags uut (.ref_clk(refClk), .rst_b(rstB),
    .req(req), .rsp(rsp), .flags(flags), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t %s got %h want %h", $time, what, seen,
        exp);
    end
  endtask

  task automatic finalReport;
    $display("Counts: %0d compares, %0d mismatches", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction

  function automatic logic [32:0] shref(input logic [1:0] op,
      input logic [31:0] b, input logic [7:0] n, input logic ci);
    logic [63:0] w;
    w = {b, b} >> n[4:0];
    if (op == 2) return {b[0], ci, b[31:1]};
    if (n == 0) return {ci, b};
    if (op == 0) return {1'b0, b} << n;
    return {w[31], w[31:0]};
  endfunction

  function automatic logic condOk(input logic [3:0] c,
      input shifter_flags_pkg::flags_t f);
    case (c)
      `CC_EQ: return f.z;
      `CC_NE: return !f.z;
      `CC_CS: return f.c;
      `CC_CC: return !f.c;
      `CC_MI: return f.n;
      `CC_PL: return !f.n;
      `CC_VS: return f.v;
      `CC_VC: return !f.v;
      `CC_HI: return f.c && !f.z;
      `CC_LS: return !f.c || f.z;
      `CC_GE: return f.n == f.v;
      `CC_LT: return f.n != f.v;
      `CC_GT: return !f.z && f.n == f.v;
      `CC_LE: return f.z || f.n != f.v;
      default: return 1'b1;
    endcase
  endfunction

  // Expected answer is queued the moment the request is launched
  task automatic issue(input shifter_flags_pkg::exec_req_t rq);
    exp_t e;
    logic [32:0] s;
    logic [31:0] a, res;
    logic ok, ft, mis, cb;
    shifter_flags_pkg::flags_t nf;
    @(posedge refClk);
    cmd <= rq;
    s = shref(rq.shift, rq.operandB, rq.amount, mf.c);
    a = rq.operandA;
    nf = mf;
    nf.c = s[32];
    res = s[31:0];
    case (rq.alu)
      shifter_flags_pkg::ALU_AND: res = a & s[31:0];
      shifter_flags_pkg::ALU_ORR: res = a | s[31:0];
      shifter_flags_pkg::ALU_EOR: res = a ^ s[31:0];
      shifter_flags_pkg::ALU_ADD, shifter_flags_pkg::ALU_COMP_ADD: begin
        {nf.c, res} = {1'b0, a} + {1'b0, s[31:0]};
        nf.v = a[31] == s[31] && res[31] != a[31];
      end
      shifter_flags_pkg::ALU_SUB, shifter_flags_pkg::ALU_COMP_SUB: begin
        {cb, res} = {1'b0, a} - {1'b0, s[31:0]};
        nf.c = !cb;
        nf.v = a[31] != s[31] && res[31] != a[31];
      end
      default: ;
    endcase
    nf.n = res[31];
    nf.z = res == 0;
    ok = condOk(rq.cond, mf);
    mis = rq.memKind == shifter_flags_pkg::MEM_HALF ? rq.memAddr[0] :
      rq.memKind >= shifter_flags_pkg::MEM_WORD && |rq.memAddr[1:0];
    ft = ok && mis && (trap || !rq.unalignOk ||
      rq.memKind > shifter_flags_pkg::MEM_WORD);
    e.st = {ok, ok && !ft && rq.alu < shifter_flags_pkg::ALU_COMP_SUB, ft};
    if (ok && !ft && rq.setFlags) mf = nf;
    if (ok) lastFault = ft;
    e.fl = mf;
    e.res = res;
    e.chk = ok && !ft;
    e.pc = (rq.instrAddr + `PC_AHEAD) & ~(rq.directBranch ? 0 : 32'h2);
    q.push_back(e);
  endtask

  task automatic drain;
    @(posedge refClk);
    cmd <= '0;
    for (int i = 0; i < 50 && q.size() > 0; i++) @(posedge refClk);
    if (q.size() > 0) begin
      check(0, 1, "answer timeout");
      finalReport();
    end
  endtask

  task automatic apb(input logic wr, input logic [`APB_AW-1:0] ad,
      input logic [31:0] wd, input logic [31:0] ed, input logic ee);
    int i;
    @(posedge refClk);
    psel <= 1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge refClk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge refClk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      check(0, 1, "apb timeout");
      finalReport();
    end else begin
      if (!wr) check(prdata, ed, "read data");
      check(32'(pslverr), 32'(ee), "error response");
      psel <= 0;
      penable <= 0;
    end
  endtask

  function automatic shifter_flags_pkg::exec_req_t rnd();
    shifter_flags_pkg::exec_req_t x;
    logic [31:0] v;
    v = lfsr();
    x.valid = 1;
    x.alu = shifter_flags_pkg::alu_op_t'(v[2:0]);
    x.shift = shifter_flags_pkg::shift_op_t'(v[4:3] % 2'd3);
    x.amount = v[5] ? {2'b0, v[11:6]} : v[13:6];
    x.setFlags = v[14];
    x.cond = v[18:15];
    x.memKind = shifter_flags_pkg::mem_kind_t'(v[21:19] % 3'd6);
    x.unalignOk = v[22];
    x.directBranch = v[23];
    x.operandA = lfsr();
    x.operandB = v[24] ? x.operandA : lfsr();
    x.memAddr = lfsr();
    x.instrAddr = lfsr();
    return x;
  endfunction

  always @(posedge refClk) begin
    if (rstB && rsp.done === 1'b1) begin
      if (q.size() == 0) check(0, 1, "unexpected answer");
      else begin
        got = q.pop_front();
        check(32'(rsp.executed), 32'(got.st[2]), "executed");
        check(32'(rsp.writeEn), 32'(got.st[1]), "write");
        check(32'(rsp.fault), 32'(got.st[0]), "fault");
        if (got.chk) check(rsp.result, got.res, "result");
        check(32'(flags), 32'(got.fl), "flags");
        check(rsp.pcValue, got.pc, "pc value");
      end
    end
  end

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    repeat (20) @(posedge refClk);
    rstB <= 1;
    apb(0, `REG_CTRL, 0, 0, 0);
    apb(0, `REG_STATUS, 0, 0, 0);
    apb(0, 12'h008, 0, 0, 1);
    $display("test register reset done");
    for (int k = 0; k < 16; k++) begin
      r = rnd();
      r.alu = shifter_flags_pkg::ALU_MOVE;
      r.shift = shifter_flags_pkg::shift_op_t'(k / 7);
      r.amount = amts[k % 7];
      r.setFlags = 1;
      r.cond = `CC_AL;
      issue(r);
    end
    drain();
    $display("test shift lengths done");
    for (int t = 0; t < 2; t++) begin
      apb(1, `REG_CTRL, t, 0, 0);
      trap = t[0];
      apb(0, `REG_CTRL, 0, t, 0);
      for (int k = 0; k < 400; k++) issue(rnd());
      drain();
      apb(0, `REG_STATUS, 0, {27'h0, lastFault, mf}, 0);
      $display("test random pass %0d done", t);
    end
    apb(1, `REG_STATUS, 32'h1F, 0, 0);
    apb(0, `REG_STATUS, 0, {27'h0, lastFault, mf}, 0);
    $display("test status write ignored done");
    finalReport();
  end
endmodule
